// File: bench/led_sink_shift_latch_driver_test.sv
`timescale 1ns/1ps
`default_nettype none

module led_sink_shift_latch_driver_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic out_en_n = 1'b1;
  logic [7:0] led_sinks_in = 8'h00;
  logic [7:0] seen;
  int fail_count = 0;
  int num_checks = 0;
  wire serial_clk;
  wire serial_din;
  wire latch_load;
  wire serial_dout;
  wire fifo_overrun;
  wire [7:0] led_sinks_out;
  wire [7:0] led_sinks_oe;

  always #4 clk_sys = ~clk_sys;

  lsd_top uut (
    .clk_sys(clk_sys),
    .reset(reset),
    .serial_clk(serial_clk),
    .serial_din(serial_din),
    .latch_load(latch_load),
    .out_en_n(out_en_n),
    .serial_dout(serial_dout),
    .led_sinks_in(led_sinks_in),
    .led_sinks_out(led_sinks_out),
    .led_sinks_oe(led_sinks_oe),
    .fifo_overrun(fifo_overrun)
  );

  lsd_host host (
    .serial_clk(serial_clk),
    .serial_din(serial_din),
    .latch_load(latch_load),
    .serial_dout(serial_dout)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle();
    repeat (10) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_blank(input logic lvl);
    @(posedge clk_sys);
    #1 out_en_n = lvl;
    settle();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    check("serial_dout", 8'h00, {7'h00, serial_dout});
    check("led_sinks_oe", 8'h00, led_sinks_oe);
    check("fifo_overrun", 8'h00, {7'h00, fifo_overrun});
    $display("test reset done");
  endtask

  task automatic t_transparent();
    set_blank(1'b0);
    host.set_load(1'b1);
    host.shift_word(8'hA5, seen);
    settle();
    check("oe transparent", 8'hA5, led_sinks_oe);
    host.shift_word(8'h5A, seen);
    settle();
    check("oe follows", 8'h5A, led_sinks_oe);
    check("chain word", 8'hA5, seen);
    host.set_load(1'b0);
    settle();
    check("oe captured", 8'h5A, led_sinks_oe);
    check("sink level", 8'h00, led_sinks_out);
    check("serial_dout", 8'h00, {7'h00, serial_dout});
    $display("test transparent done");
  endtask

  task automatic t_hold();
    host.shift_word(8'hC3, seen);
    settle();
    check("oe held", 8'h5A, led_sinks_oe);
    check("chain word", 8'h5A, seen);
    check("serial_dout", 8'h01, {7'h00, serial_dout});
    $display("test hold done");
  endtask

  task automatic t_blank();
    set_blank(1'b1);
    check("oe blanked", 8'h00, led_sinks_oe);
    host.shift_word(8'h0F, seen);
    host.set_load(1'b1);
    host.set_load(1'b0);
    settle();
    check("oe blanked", 8'h00, led_sinks_oe);
    set_blank(1'b0);
    check("oe unblanked", 8'h0F, led_sinks_oe);
    $display("test blank done");
  endtask

  task automatic t_overrun();
    host.burst(40);
    settle();
    check("fifo_overrun", 8'h01, {7'h00, fifo_overrun});
    @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    @(posedge clk_sys);
    #1;
    check("fifo_overrun", 8'h00, {7'h00, fifo_overrun});
    check("oe cleared", 8'h00, led_sinks_oe);
    check("serial_dout", 8'h00, {7'h00, serial_dout});
    $display("test overrun done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_transparent();
    t_hold();
    t_blank();
    t_overrun();
    test_done();
  end

  initial begin
    #100000;
    fail_count++;
    $display("FAIL watchdog expected done seen timeout");
    test_done();
  end
endmodule

`default_nettype wire

// File: bench/lsd_host.sv
`timescale 1ns/1ps
`default_nettype none

module lsd_host (
  output logic serial_clk,
  output logic serial_din,
  output logic latch_load,
  input wire logic serial_dout
);
  initial begin
    serial_clk = 1'b0;
    serial_din = 1'b0;
    latch_load = 1'b0;
  end

  // ==========================================================================
  // Link tasks
  // ==========================================================================
  // The data line is inverted once hold has run out, so stale bits are never seen as valid.
  task automatic shift_word(input logic [7:0] w, output logic [7:0] seen);
    for (int i = 7; i >= 0; i--) begin
      serial_din = w[i];
      #62.5;
      seen[i] = serial_dout;
      serial_clk = 1'b1;
      #40;
      serial_din = ~w[i];
      #22.5;
      serial_clk = 1'b0;
    end
  endtask

  task automatic set_load(input logic lvl);
    latch_load = lvl;
    #62.5;
  endtask

  // Deliberately faster than the queue can drain, to force a refusal.
  task automatic burst(input int n);
    repeat (n) begin
      serial_clk = 1'b1;
      #8;
      latch_load = 1'b1;
      #8;
      serial_clk = 1'b0;
      #8;
      latch_load = 1'b0;
      #8;
    end
  endtask
endmodule

`default_nettype wire

// File: rtl/lsd_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module lsd_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] nxt_wr_ptr;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW-1:0] nxt_rd_ptr;
  logic [PW:0] count_ff;
  logic [PW:0] nxt_count;
  logic push;
  logic pop;

  assign in_ready = (count_ff != DEPTH[PW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  // The storage array holds data only, so it needs no reset.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

`default_nettype wire

// File: rtl/lsd_pkg.sv
package lsd_pkg;

  // ==========================================================================
  // Word and buffer geometry
  // ==========================================================================
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;

  // Event entry layout: one entry per serial clock rise or load input change.
  localparam int ENTRY_W = 3;
  localparam int ENTRY_SHIFT = 2;
  localparam int ENTRY_DATA = 1;
  localparam int ENTRY_LOAD = 0;

  // ==========================================================================
  // Reset values and the fixed sink output level
  // ==========================================================================
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic SDO_RST = 1'b0;
  localparam logic [7:0] SINK_LEVEL = 8'h00;

  // ==========================================================================
  // Drain pacing states
  // ==========================================================================
  typedef enum logic [1:0] {
    LSD_TAKE = 2'b01,
    LSD_SETTLE = 2'b10
  } lsd_drain_t;

endpackage

// File: rtl/lsd_top.sv
// Notes on behaviour
// - Each rising serial clock edge samples the data input into stage 0 of an 8-bit shift register.
// - The serial output shows the last shift stage, renewed on each rising serial clock edge.
// - While the load input is high the output latch follows the shift register.
// - The latch captures on the falling load edge and holds while the load input is low.
// - A high output-enable-bar input switches all eight sinks off without touching the latch.
// - A low output-enable-bar input lets each sink follow its latch bit.
// - Shifting and latching work the same whatever the output-enable-bar level.
// - Reset clears the shift register and latch, so all sinks start off.
// - After reset the serial output is low whatever the input levels.
// - Drivers chain serial output to serial input with shared clock and load, eight bits each.
`timescale 1ns/1ps
`default_nettype none

module lsd_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_din,
  input wire logic latch_load,
  input wire logic out_en_n,
  output logic serial_dout,
  input wire logic [7:0] led_sinks_in,
  output logic [7:0] led_sinks_out,
  output logic [7:0] led_sinks_oe,
  output logic fifo_overrun
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [3:0] sync1_ff;
  logic [3:0] nxt_sync1;
  logic [3:0] sync2_ff;
  logic [3:0] nxt_sync2;
  logic clk_prev_ff;
  logic nxt_clk_prev;
  logic load_prev_ff;
  logic nxt_load_prev;
  logic clk_s;
  logic din_s;
  logic load_s;
  logic en_n_s;

  always_comb begin
    nxt_sync1 = {serial_clk, serial_din, latch_load, out_en_n};
    nxt_sync2 = sync1_ff;
    nxt_clk_prev = sync2_ff[3];
    nxt_load_prev = sync2_ff[1];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      clk_prev_ff <= 1'b0;
      load_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      clk_prev_ff <= nxt_clk_prev;
      load_prev_ff <= nxt_load_prev;
    end
  end

  assign clk_s = sync2_ff[3];
  assign din_s = sync2_ff[2];
  assign load_s = sync2_ff[1];
  assign en_n_s = sync2_ff[0];

  // ==========================================================================
  // Event capture into the FIFO
  // ==========================================================================
  // Clock rises and load changes share one queue so their order is kept.
  logic clk_rise;
  logic load_edge;
  logic ev_valid;
  logic ev_ready;
  logic [lsd_pkg::ENTRY_W-1:0] ev_data;
  logic q_valid;
  logic q_ready;
  logic [lsd_pkg::ENTRY_W-1:0] q_data;
  logic overrun_ff;
  logic nxt_overrun;

  assign clk_rise = clk_s && !clk_prev_ff;
  assign load_edge = load_s ^ load_prev_ff;
  assign ev_valid = clk_rise || load_edge;
  assign ev_data = {clk_rise, din_s, load_s};

  lsd_fifo #(
    .WIDTH(lsd_pkg::ENTRY_W),
    .DEPTH(lsd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(ev_valid),
    .in_ready(ev_ready),
    .in_data(ev_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // An event lost to a full queue is remembered until reset.
  always_comb begin
    nxt_overrun = overrun_ff || (ev_valid && !ev_ready);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= nxt_overrun;
    end
  end

  // ==========================================================================
  // Shift register, load level and output latch
  // ==========================================================================
  lsd_pkg::lsd_drain_t drain_ff;
  lsd_pkg::lsd_drain_t nxt_drain;
  logic [7:0] shreg_ff;
  logic [7:0] nxt_shreg;
  logic [7:0] latch_ff;
  logic [7:0] nxt_latch;
  logic load_lvl_ff;
  logic nxt_load_lvl;
  logic dout_ff;
  logic nxt_dout;
  logic pop;
  logic pop_shift;
  logic pop_load;

  // The drain takes one entry, then settles for a cycle before the next.
  assign q_ready = (drain_ff == lsd_pkg::LSD_TAKE);
  assign pop = q_valid && q_ready;
  assign pop_shift = pop && q_data[lsd_pkg::ENTRY_SHIFT];
  assign pop_load = pop && q_data[lsd_pkg::ENTRY_LOAD];

  always_comb begin
    nxt_drain = drain_ff;
    nxt_shreg = shreg_ff;
    nxt_load_lvl = load_lvl_ff;
    nxt_dout = dout_ff;
    unique case (drain_ff)
      lsd_pkg::LSD_TAKE: begin
        if (pop) begin
          nxt_drain = lsd_pkg::LSD_SETTLE;
          nxt_load_lvl = q_data[lsd_pkg::ENTRY_LOAD];
        end
      end
      lsd_pkg::LSD_SETTLE: begin
        nxt_drain = lsd_pkg::LSD_TAKE;
      end
    endcase
    if (pop_shift) begin
      nxt_shreg = {shreg_ff[6:0], q_data[lsd_pkg::ENTRY_DATA]};
      nxt_dout = shreg_ff[6];
    end
    nxt_latch = nxt_load_lvl ? nxt_shreg : latch_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drain_ff <= lsd_pkg::LSD_TAKE;
      shreg_ff <= lsd_pkg::WORD_RST;
      latch_ff <= lsd_pkg::WORD_RST;
      load_lvl_ff <= 1'b0;
      dout_ff <= lsd_pkg::SDO_RST;
    end else begin
      drain_ff <= nxt_drain;
      shreg_ff <= nxt_shreg;
      latch_ff <= nxt_latch;
      load_lvl_ff <= nxt_load_lvl;
      dout_ff <= nxt_dout;
    end
  end

  // ==========================================================================
  // Sink drive
  // ==========================================================================
  logic [7:0] sink_oe_ff;
  logic [7:0] nxt_sink_oe;

  // A sink pulls its cathode low only for a latched one while enabled.
  always_comb begin
    nxt_sink_oe = en_n_s ? 8'h00 : latch_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sink_oe_ff <= 8'h00;
    end else begin
      sink_oe_ff <= nxt_sink_oe;
    end
  end

  assign serial_dout = dout_ff;
  assign led_sinks_oe = sink_oe_ff;
  assign led_sinks_out = lsd_pkg::SINK_LEVEL;
  assign fifo_overrun = overrun_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_shift_pop;
    pop && q_data[lsd_pkg::ENTRY_SHIFT];
  endsequence

  sequence s_load_pop;
    pop && q_data[lsd_pkg::ENTRY_LOAD];
  endsequence

  // A queued clock rise must reach the shift register within a full queue's drain time.
  edge_queued_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_rise && ev_ready) |-> ##[1:34] s_shift_pop)
    else $error("serial clock rise not applied");

  shift_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_shift_pop |=> (shreg_ff == {$past(shreg_ff[6:0]), $past(q_data[lsd_pkg::ENTRY_DATA])}))
    else $error("shift register did not advance by one stage");

  dout_stage_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_shift_pop |=> (serial_dout == shreg_ff[7]) ##1 $stable(serial_dout)[*1])
    else $error("serial output is not the last stage");

  latch_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    (s_shift_pop ##0 q_data[lsd_pkg::ENTRY_LOAD]) |=> (latch_ff == shreg_ff))
    else $error("transparent latch failed to follow shifting");

  latch_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!load_lvl_ff && !pop_load) |=> (latch_ff == $past(latch_ff)))
    else $error("closed latch changed");

  blank_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_n_s |=> (led_sinks_oe == 8'h00))
    else $error("sink driven while blanked");

  sink_show_a: assert property (@(posedge clk_sys) disable iff (reset)
    !en_n_s |=> (led_sinks_oe == $past(latch_ff)))
    else $error("sink does not match latch bit");

  blank_indep_a: assert property (@(posedge clk_sys) disable iff (reset)
    (en_n_s and s_load_pop) |=> (latch_ff == shreg_ff))
    else $error("latch load blocked by blanking");

  reset_clear_a: assert property (@(posedge clk_sys)
    reset |=> (shreg_ff == 8'h00 && latch_ff == 8'h00 && !serial_dout
               && led_sinks_oe == 8'h00))
    else $error("reset left state uncleared");

  drain_pace_a: assert property (@(posedge clk_sys) disable iff (reset)
    pop |=> !pop ##1 (q_ready == 1'b1))
    else $error("drain pacing broken");

endmodule

`default_nettype wire

// File: rtl/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
